//--- design/bus_retry_ctl.sv
// bus controller core: retry, double fault halt and access ordering
// assumes a data unit above it and bus slaves plus an arbiter on pins
`timescale 1ns/10ps
`default_nettype none
module bus_retry_ctl (
    input  wire logic                        ref_clk,        // bus clock
    input  wire logic                        nrst,           // async reset
    // operand read requests, held until rd_done or rd_error
    input  wire logic                        rd_req,         // read wanted
    input  wire logic [bus_ctl_pkg::ADDR_W-1:0] rd_addr,     // read address
    input  wire logic                        rd_serial,      // serialized page
    input  wire logic                        rd_line,        // line read
    input  wire logic                        rd_burst_inh,   // burst inhibited
    input  wire logic                        rd_lock,        // locked read
    output logic                             rd_done,        // read finished
    output logic                             rd_error,       // read bus error
    output logic [bus_ctl_pkg::DATA_W-1:0]   rd_data,        // read data
    // write-back requests
    input  wire logic                        wr_req,         // write offered
    input  wire logic [bus_ctl_pkg::ADDR_W-1:0] wr_addr,     // write address
    input  wire logic [bus_ctl_pkg::DATA_W-1:0] wr_data,     // write data
    input  wire logic                        wr_lock_last,   // ends lock
    input  wire logic                        wr_push,        // cache push
    input  wire logic                        wr_cache_hit,   // hits dcache
    output logic                             wr_ready,       // queue room
    output logic                             wr_done,        // write finished
    output logic                             wr_error,       // write error
    output logic                             cache_wr_en,    // update line
    // snoop result and exception side
    input  wire logic                        push_invalid,   // push killed
    input  wire logic                        exc_stacking,   // stacking frame
    input  wire logic                        sync_instruction, // sync issued
    output logic                             sync_busy,      // stall core
    // external bus pins
    input  wire logic                        transfer_ack_n, // acknowledge
    input  wire logic                        transfer_error_ack_n, // error
    input  wire logic                        bus_grant_in_n, // grant
    input  wire logic [bus_ctl_pkg::DATA_W-1:0] bus_data_in, // data in
    output logic                             bus_request_out,// request
    output logic                             bus_oe,         // pins driven
    output logic                             ts_out,         // transfer start
    output logic                             rw_out,         // high on read
    output logic                             line_out,       // line size
    output logic [bus_ctl_pkg::ADDR_W-1:0]   addr_out,       // address
    output logic [bus_ctl_pkg::DATA_W-1:0]   data_out,       // write data
    output logic                             data_oe,        // data driven
    output logic                             lock_out,       // locked cycle
    output logic                             locked_sequence_last, // lock end
    output logic [3:0]                       processor_status_code, // status
    output logic                             halted          // double fault
);
    import bus_ctl_pkg::*;

    localparam int QW = ADDR_W + DATA_W + 2;

    bus_state_t        st_reg;
    term_t             term;
    logic              grant;
    logic [DATA_W-1:0] sdata;
    logic [QW-1:0]     q_head;
    logic              q_any;
    logic              q_hit;
    logic              q_pop;
    logic              q_push;
    logic              pick_wr;
    logic              start;
    logic [1:0]        beat_reg;
    logic              cur_wr_reg;
    logic              cur_line_reg;
    logic              cur_bi_reg;
    logic              cur_lock_reg;
    logic              cur_last_reg;
    logic              cur_push_reg;
    logic              fin_ok;
    logic              fin_err;
    logic              do_retry;
    logic              drop_push;

    term_sync u_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .ack_n   (transfer_ack_n),
        .err_n   (transfer_error_ack_n),
        .grant_n (bus_grant_in_n),
        .din     (bus_data_in),
        .term    (term),
        .grant   (grant),
        .dout    (sdata)
    );

    assign q_push = wr_req && wr_ready && (st_reg != ST_HALT);

    write_queue #(
        .DEPTH (WQ_DEPTH),
        .W     (QW)
    ) u_wq (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .push      (q_push),
        .push_data ({wr_push, wr_lock_last, wr_data, wr_addr}),
        .pop       (q_pop),
        .chk_addr  (rd_addr),
        .head      (q_head),
        .not_empty (q_any),
        .collide   (q_hit),
        .ready     (wr_ready)
    );

    // choose the next access: reads first unless a write must drain
    always_comb begin
        pick_wr = 1'b0;
        if (q_any && !rd_req) begin
            pick_wr = 1'b1;
        end else if (q_any && rd_req && q_hit) begin
            pick_wr = 1'b1;
        end else if (q_any && rd_req && rd_serial) begin
            pick_wr = 1'b1;
        end
    end
    // otherwise a waiting read goes ahead of queued writes
    // write entries carry no page marking at all

    assign start = (st_reg == ST_IDLE) && (rd_req || q_any);

    // outcome of the current beat
    always_comb begin
        fin_ok    = 1'b0;
        fin_err   = 1'b0;
        do_retry  = 1'b0;
        drop_push = 1'b0;
        if (st_reg == ST_DATA) begin
            case (term)
                TERM_DONE: begin
                    fin_ok = !cur_line_reg || (beat_reg == LAST_BEAT);
                end
                TERM_ERR: begin
                    fin_err = 1'b1;
                end
                TERM_RETRY: begin
                    if (beat_reg != FIRST_BEAT) begin
                        fin_err = 1'b1;
                    end else if (cur_push_reg && !grant && push_invalid) begin
                        drop_push = 1'b1;
                    end else begin
                        do_retry = 1'b1;
                    end
                end
                default: begin
                    fin_ok = 1'b0;                     // wait state
                end
            endcase
        end
    end

    assign q_pop = cur_wr_reg && (fin_ok || fin_err || drop_push);

    // bus state machine; halt is left only by nrst
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= ST_IDLE;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    if (start) st_reg <= grant ? ST_START : ST_ARB;
                end
                ST_ARB: begin
                    if (grant) st_reg <= ST_START;
                end
                ST_START: begin
                    st_reg <= ST_DATA;
                end
                ST_DATA: begin
                    if (fin_err && exc_stacking) begin
                        st_reg <= ST_HALT;
                    end else if (do_retry) begin
                        st_reg <= grant ? ST_START : ST_ARB;
                    end else if (fin_ok || fin_err || drop_push) begin
                        st_reg <= ST_IDLE;
                    end
                end
                ST_HALT: begin
                    st_reg <= ST_HALT;
                end
                default: begin
                    st_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // latch the attributes of the chosen access; retries reuse them unchanged
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cur_wr_reg   <= 1'b0;
            cur_line_reg <= 1'b0;
            cur_bi_reg   <= 1'b0;
            cur_lock_reg <= 1'b0;
            cur_last_reg <= 1'b0;
            cur_push_reg <= 1'b0;
            addr_out     <= '0;
            data_out     <= '0;
        end else if (start) begin
            cur_wr_reg   <= pick_wr;
            cur_line_reg <= !pick_wr && rd_line;
            cur_bi_reg   <= !pick_wr && rd_burst_inh;
            cur_lock_reg <= pick_wr ? q_head[QW-2] : rd_lock;
            cur_last_reg <= pick_wr && q_head[QW-2];
            cur_push_reg <= pick_wr && q_head[QW-1];
            addr_out     <= pick_wr ? q_head[ADDR_W-1:0] : rd_addr;
            data_out     <= q_head[ADDR_W+DATA_W-1:ADDR_W];
        end else if (st_reg == ST_DATA && term == TERM_DONE && cur_line_reg) begin
            addr_out[3:2] <= addr_out[3:2] + 2'h1;
        end
    end

    // beat counter inside a line; a burst-inhibited line counts the same
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            beat_reg <= FIRST_BEAT;
        end else if (start) begin
            beat_reg <= FIRST_BEAT;
        end else if (st_reg == ST_DATA && term == TERM_DONE && cur_line_reg) begin
            beat_reg <= beat_reg + 2'h1;
        end
    end

    // pin drive; everything is released once halted
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bus_request_out <= 1'b0;
            bus_oe          <= 1'b0;
            data_oe         <= 1'b0;
            ts_out          <= 1'b0;
            rw_out          <= 1'b1;
            line_out        <= 1'b0;
        end else if (st_reg == ST_HALT) begin
            bus_request_out <= 1'b0;
            bus_oe          <= 1'b0;
            data_oe         <= 1'b0;
            ts_out          <= 1'b0;
            rw_out          <= 1'b1;
            line_out        <= 1'b0;
        end else begin
            bus_request_out <= (st_reg == ST_ARB) || start || (st_reg == ST_START)
                               || ((st_reg == ST_DATA) && !fin_ok);
            bus_oe          <= (st_reg == ST_START) || (st_reg == ST_DATA);
            data_oe         <= cur_wr_reg && ((st_reg == ST_START)
                               || (st_reg == ST_DATA));
            ts_out          <= (st_reg == ST_START);
            rw_out          <= !cur_wr_reg;
            line_out        <= cur_line_reg;
        end
    end

    // lock held across the read, the write and all their retries
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lock_out             <= 1'b0;
            locked_sequence_last <= 1'b0;
        end else if (st_reg == ST_HALT) begin
            lock_out             <= 1'b0;
            locked_sequence_last <= 1'b0;
        end else if ((fin_ok || fin_err) && cur_last_reg) begin
            lock_out             <= 1'b0;
            locked_sequence_last <= 1'b0;
        end else if (st_reg == ST_START && cur_lock_reg) begin
            lock_out             <= 1'b1;
            locked_sequence_last <= cur_last_reg;
        end
    end

    // completions toward the data unit; a first-beat retry that repeats the access raises nothing
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_done  <= 1'b0;
            rd_error <= 1'b0;
            wr_done  <= 1'b0;
            wr_error <= 1'b0;
            rd_data  <= '0;
        end else begin
            rd_done  <= !cur_wr_reg && fin_ok;
            rd_error <= !cur_wr_reg && fin_err;
            wr_done  <= cur_wr_reg && (fin_ok || drop_push);
            wr_error <= cur_wr_reg && fin_err;
            if (st_reg == ST_DATA && term == TERM_DONE && !cur_wr_reg) begin
                rd_data <= sdata;
            end
        end
    end

    // cache line updated as the write enters the queue
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cache_wr_en <= 1'b0;
        end else begin
            cache_wr_en <= q_push && wr_cache_hit;
        end
    end

    // stall while any access is queued or on the bus
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sync_busy <= 1'b0;
        end else begin
            sync_busy <= sync_instruction && (q_any || q_push
                         || (st_reg != ST_IDLE));
        end
    end

    // status code and halt flag
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            processor_status_code <= PST_RUN;
            halted                <= 1'b0;
        end else if (st_reg == ST_HALT) begin
            processor_status_code <= PST_HALT;
            halted                <= 1'b1;
        end else begin
            processor_status_code <= PST_RUN;
            halted                <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- design/bus_ctl_pkg.sv
// constants and types shared by the bus retry and ordering logic
// assumes one bus clock and an external active-low asynchronous reset
package bus_ctl_pkg;
    localparam int          ADDR_W    = 32;
    localparam int          DATA_W    = 32;
    localparam int          WQ_DEPTH  = 4;
    localparam logic [3:0]  PST_HALT  = 4'h5;
    localparam logic [3:0]  PST_RUN   = 4'h0;
    localparam logic [1:0]  LAST_BEAT = 2'h3;
    localparam logic [1:0]  FIRST_BEAT = 2'h0;

    typedef enum logic [1:0] {
        TERM_WAIT  = 2'b00,
        TERM_DONE  = 2'b01,
        TERM_ERR   = 2'b10,
        TERM_RETRY = 2'b11
    } term_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ARB   = 3'b001,
        ST_START = 3'b010,
        ST_DATA  = 3'b011,
        ST_HALT  = 3'b100
    } bus_state_t;
endpackage

//--- design/term_sync.sv
// synchronises the termination pins, grant and read data
// assumes all inputs come from outside the bus clock domain
`timescale 1ns/10ps
`default_nettype none
module term_sync (
    input  wire logic                       ref_clk,     // bus clock
    input  wire logic                       nrst,        // async reset, low
    input  wire logic                       ack_n,       // raw acknowledge
    input  wire logic                       err_n,       // raw error ack
    input  wire logic                       grant_n,     // raw bus grant
    input  wire logic [bus_ctl_pkg::DATA_W-1:0] din,     // raw read data
    output bus_ctl_pkg::term_t              term,        // decoded termination
    output logic                            grant,       // synced grant
    output logic [bus_ctl_pkg::DATA_W-1:0]  dout         // synced data
);
    import bus_ctl_pkg::*;

    logic [2:0]        s1_reg;
    logic [2:0]        s2_reg;
    logic [DATA_W-1:0] d1_reg;
    logic [DATA_W-1:0] d2_reg;

    // two flops on every pin; data kept aligned with the strobes
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s1_reg <= 3'h7;
            s2_reg <= 3'h7;
            d1_reg <= '0;
            d2_reg <= '0;
        end else begin
            s1_reg <= {grant_n, err_n, ack_n};
            s2_reg <= s1_reg;
            d1_reg <= din;
            d2_reg <= d1_reg;
        end
    end

    // both strobes sampled together decide the outcome
    always_comb begin
        case ({s2_reg[1], s2_reg[0]})
            2'b10:   term = TERM_DONE;
            2'b01:   term = TERM_ERR;
            2'b00:   term = TERM_RETRY;
            default: term = TERM_WAIT;
        endcase
    end

    assign grant = ~s2_reg[2];
    assign dout  = d2_reg;
endmodule
`default_nettype wire

//--- design/write_queue.sv
// in-order queue of pending writes with read collision check
// assumes push and pop come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module write_queue #(
    parameter int DEPTH = bus_ctl_pkg::WQ_DEPTH,   // pending writes
    parameter int W     = 66                       // entry width
) (
    input  wire logic          ref_clk,    // bus clock
    input  wire logic          nrst,       // async reset, low
    input  wire logic          push,       // store an entry
    input  wire logic [W-1:0]  push_data,  // entry to store
    input  wire logic          pop,        // head has finished
    input  wire logic [31:0]   chk_addr,   // read address to compare
    output logic [W-1:0]       head,       // oldest entry
    output logic               not_empty,  // writes pending
    output logic               collide,    // read hits a pending write
    output logic               ready       // room for another write
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0]   mem [DEPTH];
    logic [DEPTH-1:0] vld_reg;
    logic [PW-1:0]  rd_reg;
    logic [PW-1:0]  wr_reg;
    logic [PW:0]    cnt_reg;
    logic [PW:0]    cnt_next;
    logic [DEPTH-1:0] hit;

    assign cnt_next = cnt_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};

    // pointers and count; oldest leaves first so writes stay in order
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_reg  <= '0;
            wr_reg  <= '0;
            cnt_reg <= '0;
            ready   <= 1'b1;
            vld_reg <= '0;
        end else begin
            if (push) wr_reg <= PW'(wr_reg + 1'b1);
            if (pop)  rd_reg <= PW'(rd_reg + 1'b1);
            cnt_reg <= cnt_next;
            ready   <= (cnt_next != (PW+1)'(DEPTH));
            if (push) vld_reg[wr_reg] <= 1'b1;
            if (pop)  vld_reg[rd_reg] <= 1'b0;
        end
    end

    // entry storage
    always_ff @(posedge ref_clk) begin
        if (push) mem[wr_reg] <= push_data;
    end

    // compare the read longword address with every live entry
    for (genvar i = 0; i < DEPTH; i++) begin : g_cmp
        assign hit[i] = vld_reg[i] && (mem[i][31:2] == chk_addr[31:2]);
    end

    assign collide   = |hit;
    assign head      = mem[rd_reg];
    assign not_empty = (cnt_reg != '0);
endmodule
`default_nettype wire

//--- testbench/bus_retry_checker.sv
// assertions on the controller pins
// assumes a bind by port name
`timescale 1ns/10ps
`default_nettype none
module bus_retry_checker (
    input wire logic        ref_clk, // clock
    input wire logic        nrst, // reset, low
    input wire logic        wr_req, // write offered
    input wire logic        wr_ready, // queue room
    input wire logic        wr_cache_hit, // cache hit
    input wire logic        cache_wr_en, // line update
    input wire logic        rd_done, // read ok
    input wire logic        rd_error, // read error
    input wire logic        wr_done, // write ok
    input wire logic        transfer_ack_n, // ack pin
    input wire logic        transfer_error_ack_n, // error pin
    input wire logic        bus_request_out, // request
    input wire logic        bus_oe, // pins driven
    input wire logic        ts_out, // start
    input wire logic        line_out, // line
    input wire logic [31:0] addr_out, // address
    input wire logic        lock_out, // locked
    input wire logic        locked_sequence_last, // lock end
    input wire logic [3:0]  processor_status_code, // status
    input wire logic        halted // halted
);
    logic [1:0]  beat_reg; // acks seen in this transfer
    logic        rty_reg; // a first-beat retry awaits reissue
    logic [31:0] adr_reg; // address of the last start
    wire both = !transfer_ack_n && !transfer_error_ack_n;
    wire ack1 = !transfer_ack_n && transfer_error_ack_n;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // beat count and address a retry repeats
    always_ff @(posedge ref_clk or negedge nrst)
        if (!nrst) {beat_reg, rty_reg, adr_reg} <= 35'h0;
        else if (ts_out) {beat_reg, rty_reg, adr_reg} <= {3'h0, addr_out};
        else {beat_reg, rty_reg} <= {beat_reg + {1'b0, ack1}, rty_reg | (both && beat_reg == 2'h0)};
    sequence s_fault; transfer_ack_n && !transfer_error_ack_n; endsequence
    sequence s_report; ##[1:5] (rd_error || halted); endsequence
    property p_err; s_fault |-> s_report; endproperty
    a_err: assert property (p_err) else $error("error not reported");
    property p_done; ack1 && (!line_out || beat_reg == 2'h3) |-> ##[1:4] (rd_done || wr_done);
    endproperty
    a_done: assert property (p_done) else $error("ack not completed");
    property p_same; ts_out && rty_reg |-> addr_out == adr_reg; endproperty
    a_same: assert property (p_same) else $error("retry changed address");
    property p_retry_ok; both && !halted |=> !halted [*4]; endproperty
    a_retry_ok: assert property (p_retry_ok) else $error("retry halted");
    property p_lock; lock_out && both |=> lock_out [*3]; endproperty
    a_lock: assert property (p_lock) else $error("lock dropped on retry");
    property p_locked_sequence_last; locked_sequence_last && both |=> locked_sequence_last [*3]; endproperty
    a_locked_sequence_last: assert property (p_locked_sequence_last) else $error("lock end dropped");
    property p_halt_code; halted |-> processor_status_code == 4'h5; endproperty
    a_halt_code: assert property (p_halt_code) else $error("halt status wrong");
    property p_halt_quiet; halted |-> !bus_request_out && !bus_oe; endproperty
    a_halt_quiet: assert property (p_halt_quiet) else $error("halted bus driven");
    property p_halt_stay; halted |=> halted; endproperty
    a_halt_stay: assert property (p_halt_stay) else $error("left halt");
    property p_cache; wr_req && wr_ready && wr_cache_hit |=> cache_wr_en; endproperty
    a_cache: assert property (p_cache) else $error("cache not updated");
endmodule
`default_nettype wire

//--- testbench/slave_model.sv
// slave model answering transfer beats
// assumes one start pulse per transfer
`timescale 1ns/10ps
`default_nettype none
module slave_model (
    input  wire logic        ref_clk, // clock
    input  wire logic        ts_out, // transfer start
    input  wire logic        line_out, // four beats
    input  wire logic [31:0] addr_out, // address
    input  wire logic [1:0]  bad, // fault code, 3 retry, 2 error
    input  wire logic [1:0]  bad_beat, // beat that faults
    input  wire logic [3:0]  bad_cnt, // faults to give
    output logic             ack_n, // acknowledge pin
    output logic             err_n, // error pin
    output logic [31:0]      dq // read data pin
);
    int beat = -1;
    int cnt = 0;
    initial {ack_n, err_n, dq} = {2'h3, 32'h0};
    // a beat every other cycle, one cycle low
    always @(posedge ref_clk) begin
        {ack_n, err_n} <= 2'h3;
        dq <= ~dq; // released data toggles
        if (bad == 2'h0) cnt <= 0;
        if (ts_out) beat <= 0;
        else if (beat >= 0 && ack_n && err_n) begin
            if (beat == bad_beat && cnt < bad_cnt && bad != 2'h0) begin
                {err_n, ack_n} <= ~bad;
                cnt <= cnt + 1;
                beat <= -1;
            end else begin
                ack_n <= 1'b0;
                dq <= addr_out ^ 32'hC3C3_0000;
                beat <= (line_out && beat < 3) ? beat + 1 : -1;
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// top bench: stimulus, grant, slave, checks
// assumes the slave answers every start
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        ref_clk = 1'b0, nrst = 1'b0, bus_grant_in_n = 1'b0, rd_req = 1'b0;
    logic        rd_serial = 1'b0, rd_line = 1'b0, rd_burst_inh = 1'b0, rd_lock = 1'b0;
    logic        wr_req = 1'b0, wr_lock_last = 1'b0, wr_push = 1'b0, wr_cache_hit = 1'b0;
    logic        exc_stacking = 1'b0, sync_instruction = 1'b0, ok, first_rw;
    logic [31:0] rd_addr = 32'h0, wr_addr = 32'h0, wr_data = 32'h0, a;
    logic [1:0]  bad = 2'h0, bad_beat = 2'h0;
    logic [3:0]  bad_cnt = 4'h0, processor_status_code;
    logic        rd_done, rd_error, wr_ready, wr_done, wr_error, cache_wr_en, sync_busy;
    logic        transfer_ack_n, transfer_error_ack_n, bus_request_out, bus_oe, ts_out;
    logic        rw_out, line_out, data_oe, lock_out, locked_sequence_last, halted;
    logic [31:0] rd_data, bus_data_in, addr_out, data_out;
    int          errors = 0, num_checks = 0, cycles = 0, n_ts = 0, seed = 32'h07E9;
    bus_retry_ctl dut (.*, .push_invalid(1'b0));
    slave_model slave (.ref_clk, .ts_out, .line_out, .addr_out, .bad, .bad_beat, .bad_cnt,
        .ack_n(transfer_ack_n), .err_n(transfer_error_ack_n), .dq(bus_data_in));
    always #2 ref_clk = ~ref_clk;
    // counts starts, notes the second direction, ends a hang
    always @(posedge ref_clk) begin
        if (ts_out === 1'b1 && n_ts == 1) first_rw <= rw_out;
        if (ts_out === 1'b1) n_ts <= n_ts + 1;
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            results();
        end
    end
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic setbad(logic [1:0] b, logic [1:0] bt, logic [3:0] c);
        bad = 2'h0;
        tick();
        {bad, bad_beat, bad_cnt} = {b, bt, c};
    endtask
    task automatic rd(logic [31:0] ad);
        int k = 0;
        tick();
        {rd_addr, rd_req} = {ad, 1'b1};
        do begin
            tick();
            k++;
        end while (rd_done !== 1'b1 && rd_error !== 1'b1 && k < 400);
        ok = rd_done;
        rd_req = 1'b0;
    endtask
    task automatic wr(logic [31:0] ad, logic last);
        tick();
        {wr_addr, wr_data, wr_lock_last, wr_req} = {ad, $random(seed), last, 1'b1};
        {wr_cache_hit, wr_push} = 2'($random(seed));
        while (wr_ready !== 1'b1) tick();
        tick();
        wr_req = 1'b0;
    endtask
    task automatic results();
        if (errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (10) tick();
        nrst = 1'b1;
        // reads retried 0 to 3 times, half while stacking
        for (int i = 0; i < 24; i++) begin
            a = $random(seed);
            setbad(2'h3, 2'h0, 4'(i % 4));
            {exc_stacking, n_ts} = {i[0], 32'h0};
            rd(a);
            chk("read ok", 1, ok);
            chk("read data", a ^ 32'hC3C3_0000, rd_data);
            chk("starts", i % 4 + 1, n_ts);
        end
        // line reads: first-beat retry repeats, later retry aborts
        {exc_stacking, rd_line} = 2'b01;
        for (int k = 0; k < 4; k++) begin
            rd_burst_inh = k[0];
            setbad(2'h3, k[1] ? 2'h2 : 2'h0, 4'h1);
            rd($random(seed));
            chk("line ok", !k[1], ok);
        end
        rd_line = 1'b0;
        // queued writes vs plain, serialized, colliding reads
        for (int k = 0; k < 3; k++) begin
            bus_grant_in_n = 1'b1;
            wr(32'h0000_1000, 1'b0);
            wr(32'h0000_2000, 1'b0);
            {rd_serial, n_ts} = {k == 1, 32'h0};
            fork
                rd(k == 2 ? 32'h0000_2000 : 32'h0000_3000);
                begin
                    repeat (4) tick();
                    bus_grant_in_n = 1'b0;
                end
            join
            chk("first read", k == 0, first_rw);
            {rd_serial, sync_instruction} = 2'b01;
            repeat (2) tick();
            chk("sync stall", k == 0, sync_busy);
            for (int j = 0; j < 200 && sync_busy !== 1'b0; j++) tick();
            sync_instruction = 1'b0;
        end
        // locked read and final write, both retried
        rd_lock = 1'b1;
        setbad(2'h3, 2'h0, 4'h2);
        rd(32'h0000_4000);
        rd_lock = 1'b0;
        chk("lock held", 1, lock_out);
        setbad(2'h3, 2'h0, 4'h1);
        wr(32'h0000_4000, 1'b1);
        for (int j = 0; j < 100 && lock_out !== 1'b0; j++) tick();
        chk("lock end", 0, {lock_out, locked_sequence_last});
        // stacking error halts; only reset restarts
        setbad(2'h2, 2'h0, 4'h1);
        exc_stacking = 1'b1;
        rd(32'h0000_5000);
        rd(32'h0000_6000);
        chk("halt", 7'h54, {halted, processor_status_code, bus_request_out, bus_oe});
        nrst = 1'b0;
        tick();
        {nrst, exc_stacking} = 2'b10;
        setbad(2'h0, 2'h0, 4'h0);
        rd(32'h0000_7000);
        chk("restart", 6'h01, {halted, processor_status_code, ok});
        results();
    end
endmodule
bind bus_retry_ctl bus_retry_checker chk_u (.*);
`default_nettype wire
